// ### tsi_pkg.sv
// Constants and types shared by the temperature status and indication block.
// Function
// - Each 12-bit converter sample is taken as one conversion result.
// - Each sample is scaled and, except the first after reset, filtered by the filter rate before it becomes the measurement.
// - Measurement and status are held on output ports for the bus front end.
// - Node address is 0xFE after reset, the same on every unit.
// - A bus write to the address register sets a new node address.
// - While the push switch is pressed the node address is forced to 0xFF.
// - Settings live in a store at fixed register numbers 04h and 20h.
// - The display shows the measurement with one decimal, or an error word.
// - Above 85.0 shows the over-range word, below -40.0 the under-range word.
// - Sensor fault shows the error word, water inside shows the humidity word.
// - In normal running the board LED blinks with a 1 s period.
// - While the sensor has failed the board LED blinks five times a second.
// - While the address is forced the board LED stays lit.
// - Status is the OR of 10h water, 20h sensor, 40h under, 80h over.
// - Filter rate runs 0 (none) to 5 (strongest); larger writes are ignored.
package tsi_pkg;

  // ==========================================================================
  // Clock and indicator timing
  localparam int unsigned CLK_HZ             = 25_000_000;
  localparam int unsigned LED_NORM_PERIOD_MS = 1000;
  localparam int unsigned LED_FAST_RATE_HZ   = 5;
  localparam int unsigned LED_NORM_HALF_CYC  = CLK_HZ / 1000 * LED_NORM_PERIOD_MS / 2;
  localparam int unsigned LED_FAST_HALF_CYC  = CLK_HZ / LED_FAST_RATE_HZ / 2;

  // ==========================================================================
  // Settings store
  localparam logic [7:0] REG_FILTER     = 8'h04;
  localparam logic [7:0] REG_NODE_ADDR  = 8'h20;
  localparam int         CFG_WORDS      = 2;
  localparam int         CFG_IDX_FILTER = 0;
  localparam int         CFG_IDX_ADDR   = 1;
  localparam logic [7:0] ADDR_FACTORY   = 8'hFE;
  localparam logic [7:0] ADDR_FORCED    = 8'hFF;
  localparam logic [7:0] FILTER_RESET   = 8'h00;
  localparam logic [7:0] FILTER_MAX     = 8'h05;

  // ==========================================================================
  // Measurement
  localparam int          SAMPLE_W   = 12;
  localparam int          MEAS_W     = 16;
  localparam int          FRAC_BITS  = 5;
  localparam int          ACC_W      = MEAS_W + FRAC_BITS;
  localparam logic signed [15:0] MEAS_MIN = 16'shFE70;
  localparam logic signed [15:0] MEAS_MAX = 16'sh0352;
  localparam logic [7:0]  ST_WATER   = 8'h10;
  localparam logic [7:0]  ST_SENSOR  = 8'h20;
  localparam logic [7:0]  ST_UNDER   = 8'h40;
  localparam logic [7:0]  ST_OVER    = 8'h80;
  localparam int          ST_BIT_WATER  = 4;
  localparam int          ST_BIT_SENSOR = 5;
  localparam int          ST_BIT_UNDER  = 6;
  localparam int          ST_BIT_OVER   = 7;

  // ==========================================================================
  // Display glyph codes; 00h to 09h are the decimal digits.
  localparam int         GLY_W     = 5;
  localparam int         DIGITS    = 4;
  localparam logic [4:0] GLY_MINUS = 5'h0A;
  localparam logic [4:0] GLY_BLANK = 5'h0B;
  localparam logic [4:0] GLY_HI_H  = 5'h0C;
  localparam logic [4:0] GLY_LO_I  = 5'h0D;
  localparam logic [4:0] GLY_HI_L  = 5'h0E;
  localparam logic [4:0] GLY_LO_O  = 5'h0F;
  localparam logic [4:0] GLY_HI_E  = 5'h10;
  localparam logic [4:0] GLY_LO_R  = 5'h11;
  localparam logic [4:0] GLY_LO_H  = 5'h12;
  localparam logic [4:0] GLY_LO_U  = 5'h13;
  localparam logic [4:0] GLY_LO_M  = 5'h14;
  localparam logic [3:0] DP_TENTHS = 4'h2;
  localparam logic [3:0] DP_NONE   = 4'h0;

  typedef enum logic [1:0] {
    TSI_LED_NORMAL,
    TSI_LED_FAULT,
    TSI_LED_FORCED
  } tsi_led_mode_t;

endpackage

// ### tsi_cfg_mem.sv
// Small settings store with one write port and registered read words.
`timescale 1ns/1ps
module tsi_cfg_mem (
  input  wire logic                                      i_clk,
  input  wire logic                                      i_sys_rst,
  input  wire logic                                      i_wr_en,
  input  wire logic [0:0]                                i_wr_idx,
  input  wire logic [7:0]                                i_wr_data,
  output logic      [tsi_pkg::CFG_WORDS-1:0][7:0]        o_rd_data
);

  localparam logic [tsi_pkg::CFG_WORDS-1:0][7:0] RESET_WORDS =
    {tsi_pkg::ADDR_FACTORY, tsi_pkg::FILTER_RESET};

  // ==========================================================================
  // Storage words
  for (genvar g = 0; g < tsi_pkg::CFG_WORDS; g++) begin : g_word
    logic [7:0] next_word;

    always_comb begin
      next_word = o_rd_data[g];
      if (i_wr_en && (i_wr_idx == 1'(g))) begin
        next_word = i_wr_data;
      end
    end

    always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
        o_rd_data[g] <= RESET_WORDS[g];
      end else begin
        o_rd_data[g] <= next_word;
      end
    end
  end

endmodule

// ### tsi_top.sv
// Sample filter, status, settings, display and board LED of the temperature node.
`timescale 1ns/1ps
module tsi_top #(
  parameter int unsigned P_NORM_HALF_CYC = tsi_pkg::LED_NORM_HALF_CYC,
  parameter int unsigned P_FAST_HALF_CYC = tsi_pkg::LED_FAST_HALF_CYC
) (
  input  wire logic                                     i_clk,
  input  wire logic                                     i_sys_rst,
  input  wire logic                                     i_sample_valid,
  input  wire logic [tsi_pkg::SAMPLE_W-1:0]             i_sample,
  input  wire logic                                     i_sensor_fault,
  input  wire logic                                     i_water_detect,
  input  wire logic                                     i_force_sw,
  input  wire logic                                     i_cfg_wr_valid,
  input  wire logic [7:0]                               i_cfg_wr_reg,
  input  wire logic [7:0]                               i_cfg_wr_data,
  output logic      [7:0]                               o_node_addr,
  output logic      [7:0]                               o_filter_rate,
  output logic      [tsi_pkg::MEAS_W-1:0]               o_meas,
  output logic                                          o_meas_valid,
  output logic      [7:0]                               o_status,
  output logic      [tsi_pkg::DIGITS*tsi_pkg::GLY_W-1:0] o_disp,
  output logic      [tsi_pkg::DIGITS-1:0]               o_disp_dp,
  output logic                                          o_led
);

  // ==========================================================================
  // Pin synchronisers
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic       sensor_s;
  logic       water_s;
  logic       force_s;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end else begin
      sync_a <= {i_force_sw, i_water_detect, i_sensor_fault};
      sync_b <= sync_a;
    end
  end

  assign sensor_s = sync_b[0];
  assign water_s  = sync_b[1];
  assign force_s  = sync_b[2];

  // ==========================================================================
  // Settings store
  logic                                  cfg_wr_en;
  logic [0:0]                            cfg_wr_idx;
  logic [7:0]                            cfg_wr_data;
  logic [tsi_pkg::CFG_WORDS-1:0][7:0]    cfg_words;

  always_comb begin
    cfg_wr_en   = 1'b0;
    cfg_wr_idx  = 1'(tsi_pkg::CFG_IDX_ADDR);
    cfg_wr_data = i_cfg_wr_data;
    if (force_s) begin
      cfg_wr_en   = 1'b1;
      cfg_wr_data = tsi_pkg::ADDR_FORCED;
    end else if (i_cfg_wr_valid && (i_cfg_wr_reg == tsi_pkg::REG_NODE_ADDR)) begin
      cfg_wr_en = 1'b1;
    end else if (i_cfg_wr_valid && (i_cfg_wr_reg == tsi_pkg::REG_FILTER) &&
                 (i_cfg_wr_data <= tsi_pkg::FILTER_MAX)) begin
      cfg_wr_en  = 1'b1;
      cfg_wr_idx = 1'(tsi_pkg::CFG_IDX_FILTER);
    end
  end

  tsi_cfg_mem u_cfg (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_wr_en   (cfg_wr_en),
    .i_wr_idx  (cfg_wr_idx),
    .i_wr_data (cfg_wr_data),
    .o_rd_data (cfg_words)
  );

  assign o_node_addr   = cfg_words[tsi_pkg::CFG_IDX_ADDR];
  assign o_filter_rate = cfg_words[tsi_pkg::CFG_IDX_FILTER];

  // ==========================================================================
  // Measurement, filter, status and display
  // The converter delivers 1/16 degree steps; times 10/16 gives tenths.
  localparam int ACC_W = tsi_pkg::ACC_W;

  logic signed [15:0]                        sample_w;
  logic signed [15:0]                        tenths;
  logic signed [tsi_pkg::ACC_W-1:0]          acc;
  logic signed [tsi_pkg::ACC_W-1:0]          next_acc;
  logic signed [tsi_pkg::ACC_W-1:0]          x_scaled;
  logic signed [tsi_pkg::MEAS_W-1:0]         next_meas;
  logic                                      next_meas_valid;
  logic [7:0]                                next_status;
  logic [tsi_pkg::DIGITS*tsi_pkg::GLY_W-1:0] next_disp;
  logic [tsi_pkg::DIGITS-1:0]                next_dp;
  logic [15:0]                               mag;
  logic [3:0]                                d_hund;
  logic [3:0]                                d_ten;
  logic [3:0]                                d_one;

  assign sample_w = 16'(signed'(i_sample));
  assign tenths   = 16'((sample_w <<< 2) + sample_w) >>> 3;
  assign x_scaled = ACC_W'(tenths) <<< tsi_pkg::FRAC_BITS;

  always_comb begin
    next_acc        = acc;
    next_meas_valid = o_meas_valid;
    if (i_sample_valid) begin
      next_meas_valid = 1'b1;
      if (!o_meas_valid || (o_filter_rate == 8'h00)) begin
        next_acc = x_scaled;
      end else begin
        next_acc = acc + ((x_scaled - acc) >>> o_filter_rate[2:0]);
      end
    end
    next_meas   = tsi_pkg::MEAS_W'(next_acc >>> tsi_pkg::FRAC_BITS);
    next_status = 8'h00;
    if (water_s) next_status = next_status | tsi_pkg::ST_WATER;
    if (sensor_s) next_status = next_status | tsi_pkg::ST_SENSOR;
    if (next_meas_valid && (next_meas < tsi_pkg::MEAS_MIN)) begin
      next_status = next_status | tsi_pkg::ST_UNDER;
    end
    if (next_meas_valid && (next_meas > tsi_pkg::MEAS_MAX)) begin
      next_status = next_status | tsi_pkg::ST_OVER;
    end
    mag    = next_meas[15] ? 16'(-next_meas) : 16'(next_meas);
    d_hund = 4'(mag / 16'h0064);
    d_ten  = 4'((mag / 16'h000A) % 16'h000A);
    d_one  = 4'(mag % 16'h000A);
    next_dp = tsi_pkg::DP_NONE;
    if (next_status[tsi_pkg::ST_BIT_SENSOR]) begin
      next_disp = {tsi_pkg::GLY_HI_E, tsi_pkg::GLY_LO_R, tsi_pkg::GLY_LO_R,
                   tsi_pkg::GLY_BLANK};
    end else if (next_status[tsi_pkg::ST_BIT_WATER]) begin
      next_disp = {tsi_pkg::GLY_LO_H, tsi_pkg::GLY_LO_U, tsi_pkg::GLY_LO_M,
                   tsi_pkg::GLY_LO_I};
    end else if (next_status[tsi_pkg::ST_BIT_OVER]) begin
      next_disp = {tsi_pkg::GLY_MINUS, tsi_pkg::GLY_HI_H, tsi_pkg::GLY_LO_I,
                   tsi_pkg::GLY_MINUS};
    end else if (next_status[tsi_pkg::ST_BIT_UNDER]) begin
      next_disp = {tsi_pkg::GLY_MINUS, tsi_pkg::GLY_HI_L, tsi_pkg::GLY_LO_O,
                   tsi_pkg::GLY_MINUS};
    end else if (!next_meas_valid) begin
      next_disp = {4{tsi_pkg::GLY_MINUS}};
    end else begin
      next_dp   = tsi_pkg::DP_TENTHS;
      next_disp = {next_meas[15] ? tsi_pkg::GLY_MINUS : tsi_pkg::GLY_BLANK,
                   (d_hund == 4'h0) ? tsi_pkg::GLY_BLANK : {1'b0, d_hund},
                   {1'b0, d_ten}, {1'b0, d_one}};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      acc          <= '0;
      o_meas       <= '0;
      o_meas_valid <= 1'b0;
      o_status     <= 8'h00;
      o_disp       <= {4{tsi_pkg::GLY_MINUS}};
      o_disp_dp    <= tsi_pkg::DP_NONE;
    end else begin
      acc          <= next_acc;
      o_meas       <= next_meas;
      o_meas_valid <= next_meas_valid;
      o_status     <= next_status;
      o_disp       <= next_disp;
      o_disp_dp    <= next_dp;
    end
  end

  // ==========================================================================
  // Board LED
  tsi_pkg::tsi_led_mode_t led_mode;
  logic [23:0]            led_cnt;
  logic [23:0]            next_led_cnt;
  logic                   next_led;
  logic [31:0]            half_cyc;

  always_comb begin
    if (force_s) begin
      led_mode = tsi_pkg::TSI_LED_FORCED;
    end else if (sensor_s) begin
      led_mode = tsi_pkg::TSI_LED_FAULT;
    end else begin
      led_mode = tsi_pkg::TSI_LED_NORMAL;
    end
    half_cyc     = (led_mode == tsi_pkg::TSI_LED_FAULT) ? P_FAST_HALF_CYC
                                                         : P_NORM_HALF_CYC;
    next_led_cnt = led_cnt + 24'h000001;
    next_led     = o_led;
    unique case (led_mode)
      tsi_pkg::TSI_LED_FORCED: begin
        next_led     = 1'b1;
        next_led_cnt = 24'h000000;
      end
      tsi_pkg::TSI_LED_FAULT, tsi_pkg::TSI_LED_NORMAL: begin
        if ({8'h00, led_cnt} >= (half_cyc - 32'h00000001)) begin
          next_led     = !o_led;
          next_led_cnt = 24'h000000;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      led_cnt <= 24'h000000;
      o_led   <= 1'b0;
    end else begin
      led_cnt <= next_led_cnt;
      o_led   <= next_led;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  a_force_addr: assert property (force_s |=> o_node_addr == 8'hFF)
    else $error("Forced address did not become FF.");
  a_addr_write: assert property (
    i_cfg_wr_valid && !force_s && i_cfg_wr_reg == 8'h20
    |=> o_node_addr == $past(i_cfg_wr_data))
    else $error("Written node address not adopted.");
  a_filter_reject: assert property (
    i_cfg_wr_valid && i_cfg_wr_reg == 8'h04 && i_cfg_wr_data > 8'h05
    |=> $stable(o_filter_rate))
    else $error("Out of range filter rate was stored.");
  a_force_led_lit: assert property (force_s |=> o_led)
    else $error("LED not lit while address forced.");
  a_status_over: assert property (
    o_status[7] == (o_meas_valid && $signed(o_meas) > tsi_pkg::MEAS_MAX))
    else $error("Over range flag disagrees with measurement.");
  a_status_under: assert property (
    o_status[6] == (o_meas_valid && $signed(o_meas) < tsi_pkg::MEAS_MIN))
    else $error("Under range flag disagrees with measurement.");
  a_disp_error: assert property (o_status[5] |-> o_disp[19:15] == 5'h10)
    else $error("Sensor fault not shown first.");
  a_disp_humid: assert property (
    o_status[4] && !o_status[5] |-> o_disp == {5'h12, 5'h13, 5'h14, 5'h0D})
    else $error("Water fault word not shown.");
  a_no_filter: assert property (
    i_sample_valid && o_filter_rate == 8'h00 |=> o_meas == $past(tenths))
    else $error("Unfiltered sample not passed through.");
  // After a toggle in fault mode the LED holds for at least eight cycles.
  a_fast_blink: assert property (
    sensor_s && !force_s && $changed(o_led)
    |=> (P_FAST_HALF_CYC < 32'h00000009 || force_s || !sensor_s || $stable(o_led)) [*8])
    else $error("Fault blink toggled too early.");

endmodule

// ### tsi_bus_master.sv
// Bus master model that writes settings into the block.
`timescale 1ns/1ps
module tsi_bus_master (
  input  wire logic       i_clk,
  output logic            o_wr_valid,
  output logic [7:0]      o_wr_reg,
  output logic [7:0]      o_wr_data
);
  initial begin
    o_wr_valid = 1'b0;
    o_wr_reg   = 8'h00;
    o_wr_data  = 8'h00;
  end

  // One write pulse of one cycle; released lines show the inverse of their last value.
  task automatic write_reg(input logic [7:0] num, input logic [7:0] value);
    @(posedge i_clk);
    #1;
    o_wr_valid = 1'b1;
    o_wr_reg   = num;
    o_wr_data  = value;
    @(posedge i_clk);
    #1;
    o_wr_valid = 1'b0;
    o_wr_reg   = ~num;
    o_wr_data  = ~value;
  endtask
endmodule

// ### temp_status_indicator_tb.sv
// Self-checking testbench of the temperature status and indication block.
`timescale 1ns/1ps
module temp_status_indicator_tb;
  logic        i_clk;
  logic        i_sys_rst;
  logic        i_sample_valid;
  logic [11:0] i_sample;
  logic        i_sensor_fault;
  logic        i_water_detect;
  logic        i_force_sw;
  logic        wr_valid;
  logic [7:0]  wr_reg;
  logic [7:0]  wr_data;
  logic [7:0]  o_node_addr;
  logic [7:0]  o_filter_rate;
  logic [15:0] o_meas;
  logic        o_meas_valid;
  logic [7:0]  o_status;
  logic [19:0] o_disp;
  logic [3:0]  o_disp_dp;
  logic        o_led;
  int          fails;
  int          comparisons;

  tsi_top #(.P_NORM_HALF_CYC(50), .P_FAST_HALF_CYC(10)) tsi_top_i (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_sample_valid(i_sample_valid),
    .i_sample(i_sample), .i_sensor_fault(i_sensor_fault),
    .i_water_detect(i_water_detect), .i_force_sw(i_force_sw),
    .i_cfg_wr_valid(wr_valid), .i_cfg_wr_reg(wr_reg), .i_cfg_wr_data(wr_data),
    .o_node_addr(o_node_addr), .o_filter_rate(o_filter_rate), .o_meas(o_meas),
    .o_meas_valid(o_meas_valid), .o_status(o_status), .o_disp(o_disp),
    .o_disp_dp(o_disp_dp), .o_led(o_led)
  );

  tsi_bus_master tsi_bus_master_i (
    .i_clk(i_clk), .o_wr_valid(wr_valid), .o_wr_reg(wr_reg), .o_wr_data(wr_data)
  );

  // ==========================================================================
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic send(input logic [11:0] s);
    i_sample_valid = 1'b1;
    i_sample       = s;
    cyc(1);
    i_sample_valid = 1'b0;
    cyc(3);
  endtask

  task automatic blink(input logic [31:0] half);
    logic prev;
    int   n;
    repeat (2) begin
      prev = o_led;
      n    = 0;
      while (o_led === prev && n < 200) begin
        cyc(1);
        n++;
      end
    end
    check(n, half, "led half period");
  endtask

  task automatic stop_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic test_reset;
    check(o_node_addr, 8'hFE, "factory address");
    check(o_filter_rate, 8'h00, "filter reset");
    check(o_meas_valid, 1'b0, "meas valid reset");
    check(o_disp, {4{5'h0A}}, "dashes at reset");
    $display("test reset done");
  endtask

  task automatic test_filter_cfg;
    tsi_bus_master_i.write_reg(8'h04, 8'h01);
    cyc(2);
    check(o_filter_rate, 8'h01, "filter rate 1");
    send(12'h190);
    check(o_meas, 16'h00FA, "first sample unfiltered");
    send(12'h000);
    check(o_meas, 16'h007D, "filter step one");
    send(12'h000);
    check(o_meas, 16'h003E, "filter step two");
    tsi_bus_master_i.write_reg(8'h04, 8'h06);
    tsi_bus_master_i.write_reg(8'h05, 8'h00);
    cyc(2);
    check(o_filter_rate, 8'h01, "filter 6 refused");
    tsi_bus_master_i.write_reg(8'h04, 8'h05);
    cyc(2);
    check(o_filter_rate, 8'h05, "filter rate 5");
    send(12'h000);
    check(o_meas, 16'h003C, "strongest filter step");
    tsi_bus_master_i.write_reg(8'h04, 8'h00);
    tsi_bus_master_i.write_reg(8'h20, 8'h01);
    cyc(2);
    check(o_filter_rate, 8'h00, "filter rate 0");
    check(o_node_addr, 8'h01, "address written");
    $display("test filter and settings done");
  endtask

  task automatic test_display;
    send(12'h190);
    check(o_meas_valid, 1'b1, "meas valid");
    check(o_status, 8'h00, "status valid");
    check(o_disp, {5'h0B, 5'h02, 5'h05, 5'h00}, "number shown");
    check(o_disp_dp, 4'h2, "decimal point");
    send(12'h560);
    check(o_status, 8'h80, "over status");
    check(o_disp, {5'h0A, 5'h0C, 5'h0D, 5'h0A}, "over word");
    send(12'hD70);
    check(o_status, 8'h40, "under status");
    check(o_disp, {5'h0A, 5'h0E, 5'h0F, 5'h0A}, "under word");
    i_sensor_fault = 1'b1;
    i_water_detect = 1'b1;
    cyc(4);
    check(o_status, 8'h70, "status or");
    check(o_disp, {5'h10, 5'h11, 5'h11, 5'h0B}, "error word first");
    i_sensor_fault = 1'b0;
    cyc(4);
    check(o_status, 8'h50, "water status");
    check(o_disp, {5'h12, 5'h13, 5'h14, 5'h0D}, "humidity word");
    i_water_detect = 1'b0;
    send(12'h190);
    check(o_status, 8'h00, "faults cleared");
    send(12'h550);
    check(o_status, 8'h00, "top of span valid");
    check(o_disp, {5'h0B, 5'h08, 5'h05, 5'h00}, "85.0 shown");
    send(12'hD80);
    check(o_status, 8'h00, "bottom of span valid");
    check(o_disp, {5'h0A, 5'h04, 5'h00, 5'h00}, "minus 40.0 shown");
    $display("test display done");
  endtask

  task automatic test_led;
    int bad;
    blink(32'h00000032);
    i_sensor_fault = 1'b1;
    cyc(4);
    blink(32'h0000000A);
    i_force_sw = 1'b1;
    cyc(4);
    check(o_node_addr, 8'hFF, "forced address");
    tsi_bus_master_i.write_reg(8'h20, 8'h03);
    bad = 0;
    repeat (120) begin
      cyc(1);
      if (o_led !== 1'b1) bad++;
    end
    check(bad, 32'h00000000, "led steady while forced");
    check(o_node_addr, 8'hFF, "write lost while forced");
    i_force_sw     = 1'b0;
    i_sensor_fault = 1'b0;
    cyc(4);
    check(o_node_addr, 8'hFF, "address kept after release");
    $display("test led and force done");
  endtask

  // ==========================================================================
  // Clock, reset, sequence and watchdog
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  initial begin
    fails          = 0;
    comparisons    = 0;
    i_sys_rst      = 1'b1;
    i_sample_valid = 1'b0;
    i_sample       = 12'h000;
    i_sensor_fault = 1'b0;
    i_water_detect = 1'b0;
    i_force_sw     = 1'b0;
    repeat (8) @(posedge i_clk);
    #1;
    i_sys_rst = 1'b0;
    cyc(1);
    test_reset();
    test_filter_cfg();
    test_display();
    test_led();
    stop_test();
  end

  initial begin
    #400_000;
    fails++;
    $display("unexpected at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule
